// *** src/mfm_full_duty.sv ***
// Full-duty high-side re-enable clock.
// Assumes current-limit trip is a synchronous level from the analog side.
`timescale 1ns/1ps
module mfm_full_duty (
  input  wire logic sys_clk,
  input  wire logic rst,
  input  wire logic sel_40k,
  input  wire logic pwm_in,
  input  wire logic ilim_trip,
  output logic      hs_on
);
  localparam logic [15:0] P20 = 16'(mfm_pkg::PWM20_CYC - 1);
  localparam logic [15:0] P40 = 16'(mfm_pkg::PWM40_CYC - 1);

  logic [15:0] cnt_r;
  logic        pwm_d_r;
  logic        cut_r;
  logic        hs_r;
  wire  [15:0] top     = sel_40k ? P40 : P20;
  wire         tick    = (cnt_r >= top);
  wire         pwm_rise = pwm_in & ~pwm_d_r;
  // A PWM rising edge, or the internal tick while PWM is high, ends the cut
  wire         restart = pwm_rise | (pwm_in & tick);

  always_ff @(posedge sys_clk) begin
    // Wrap on every tick so the count stays bounded while the input is low
    if (rst || pwm_rise || tick) cnt_r <= 16'h0000;
    else                cnt_r <= cnt_r + 16'h0001;
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      pwm_d_r <= 1'b0;
      cut_r   <= 1'b0;
      hs_r    <= 1'b0;
    end else begin
      pwm_d_r <= pwm_in;
      if (ilim_trip)    cut_r <= 1'b1;
      else if (restart) cut_r <= 1'b0; // R1
      hs_r <= pwm_in & ~(cut_r & ~restart) & ~ilim_trip;
    end
  end
  assign hs_on = hs_r;

  AST_TICK_REENABLE: assert property (@(posedge sys_clk) disable iff (rst) // R1
    (pwm_in && $past(pwm_in) && cut_r && tick && !ilim_trip) |=> hs_r)
    else $error("high side not re-enabled on internal tick");
  AST_PERIOD_BOUND: assert property (@(posedge sys_clk) disable iff (rst) // R2
    cnt_r <= P20)
    else $error("internal period counter overran");
endmodule : mfm_full_duty

// *** src/mfm_pkg.sv ***
// Constants, register map and types for the motor driver fault manager.
// Assumes a single 250 MHz clock and a plain register port.
//
// Notes on behaviour
// R1 - Internal clock re-enables high side at full duty
// R2 - Internal clock 20 or 40 kHz selectable
// R3 - Supply undervoltage disables FETs, pump, logic; auto resume
// R4 - Supply lost flag latched low until cleared
// R5 - Analog rail undervoltage acts like supply undervoltage
// R6 - Buck undervoltage: only buck off, fault pin, flags
// R7 - Buck recovery restarts buck; flags stay latched
// R8 - Bus error reported only when not disabled
// R9 - Trim error latches Hi-Z until sleep reset
// R10 - Pump undervoltage disables FETs, latches flag
// R11 - Overvoltage acts only when enabled
// R12 - Overcurrent action chosen by two-bit selector
// R13 - Clear command and sleep pulse clear identically; the clear command here leaves the trim latch set
package mfm_pkg;

  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam int CLK_MHZ          = 250;
  localparam int PWM20_KHZ        = 20;
  localparam int PWM40_KHZ        = 40;
  localparam int PWM20_CYC        = CLK_MHZ * 1000 / PWM20_KHZ;
  localparam int PWM40_CYC        = CLK_MHZ * 1000 / PWM40_KHZ;
  localparam int RETRY_US_DEF     = 500;
  localparam int RETRY_CYC_DEF    = RETRY_US_DEF * CLK_MHZ;
  localparam int RST_PULSE_US_DEF = 20;
  localparam int RST_PULSE_CYC_DEF = RST_PULSE_US_DEF * CLK_MHZ;
  localparam int CNT_W            = 20;

  // ---------------------------------------------------------------
  // Register map
  // ---------------------------------------------------------------
  localparam logic [3:0] ADDR_STATUS = 4'h0;
  localparam logic [3:0] ADDR_CTRL   = 4'h1;
  localparam logic [3:0] ADDR_IRQ_ST = 4'h2;
  localparam logic [3:0] ADDR_IRQ_MK = 4'h3;
  localparam logic [3:0] ADDR_LIVE   = 4'h4;

  // Status bit positions
  localparam int ST_SUPPLY_OK = 0;
  localparam int ST_FAULT     = 1;
  localparam int ST_BUCK_FLT  = 2;
  localparam int ST_BUCK_DIP  = 3;
  localparam int ST_PUMP_UV   = 4;
  localparam int ST_OVP       = 5;
  localparam int ST_OCP       = 6;
  localparam int ST_BUS_ERR   = 7;
  localparam int ST_TRIM_ERR  = 8;
  localparam int ST_W         = 9;

  // Control bit positions
  localparam int CT_CLEAR     = 0;
  localparam int CT_PWM40     = 1;
  localparam int CT_OVERVOLT_EN = 2;
  localparam int CT_BUSREP_DIS = 3;
  localparam int CT_OCP_LO    = 4;

  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [ST_W-1:0] MASK_RST = 9'h000;

  typedef enum logic [1:0] {
    MFM_OCP_LATCH  = 2'h0,
    MFM_OCP_RETRY  = 2'h1,
    MFM_OCP_REPORT = 2'h2,
    MFM_OCP_OFF    = 2'h3
  } mfm_ocp_t;

  typedef enum {MFM_OC_IDLE, MFM_OC_HOLD, MFM_OC_WAIT} mfm_oc_st_t;

  typedef struct packed {
    logic supply_uv;
    logic analog_rail_undervolt;
    logic buck_low;
    logic pump_uv;
    logic ovp;
    logic ocp;
    logic bus_err;
    logic trim_err;
  } mfm_cond_t;

  typedef struct packed {
    logic fets_en;
    logic pump_en;
    logic logic_en;
    logic buck_en;
  } mfm_enables_t;

endpackage : mfm_pkg

// *** src/mfm_top.sv ***
// Fault supervision core: latching, pin and enables, register port, interrupt.
// Assumes condition inputs are synchronous levels; sleep_n_pin synchronous.
//
// Local design decisions: the register offsets and strobed register access.
`timescale 1ns/1ps
module mfm_top #(
  parameter int RETRY_CYC     = mfm_pkg::RETRY_CYC_DEF,
  parameter int RST_PULSE_CYC = mfm_pkg::RST_PULSE_CYC_DEF
) (
  input  wire logic                sys_clk,
  input  wire logic                rst,
  input  wire mfm_pkg::mfm_cond_t  cond,
  input  wire logic                sleep_n_pin,
  input  wire logic                pwm_in,
  input  wire logic                ilim_trip,
  input  wire logic [3:0]          reg_addr,
  input  wire logic [15:0]         reg_wdata,
  input  wire logic                reg_wr,
  input  wire logic                reg_rd,
  output logic [15:0]              reg_rdata,
  output mfm_pkg::mfm_enables_t    enables,
  output logic                     hs_on,
  output logic                     fault_n_pin,
  output logic                     irq
);
  localparam int W = mfm_pkg::ST_W;

  // ---------------------------------------------------------------
  // Control register and clear sources
  // ---------------------------------------------------------------
  localparam int CNT_W_L = mfm_pkg::CNT_W;
  logic [7:0]   ctrl_r;
  logic         clr_cmd_r;
  logic [CNT_W_L-1:0] slp_cnt_r;
  logic         slp_d_r;

  wire wr_ctrl  = reg_wr && (reg_addr == mfm_pkg::ADDR_CTRL);
  wire wr_irqst = reg_wr && (reg_addr == mfm_pkg::ADDR_IRQ_ST);
  wire wr_mask  = reg_wr && (reg_addr == mfm_pkg::ADDR_IRQ_MK);
  wire clr_write = wr_ctrl && reg_wdata[mfm_pkg::CT_CLEAR];
  wire sel_40k   = ctrl_r[mfm_pkg::CT_PWM40];
  wire overvolt_enable = ctrl_r[mfm_pkg::CT_OVERVOLT_EN];
  wire busrep_dis = ctrl_r[mfm_pkg::CT_BUSREP_DIS];
  wire mfm_pkg::mfm_ocp_t ocp_sel = mfm_pkg::mfm_ocp_t'(ctrl_r[mfm_pkg::CT_OCP_LO +: 2]);

  // A low pulse at least the reset width counts, seen on the rising edge
  wire slp_rise   = sleep_n_pin & ~slp_d_r;
  wire slp_clear  = slp_rise && (slp_cnt_r >= CNT_W_L'(RST_PULSE_CYC));
  wire clear_all  = clr_cmd_r | slp_clear; // R13

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      ctrl_r    <= mfm_pkg::CTRL_RST;
      clr_cmd_r <= 1'b0;
      slp_d_r   <= 1'b1;
      slp_cnt_r <= '0;
    end else begin
      if (wr_ctrl) ctrl_r <= {reg_wdata[7:1], 1'b0};
      clr_cmd_r <= clr_write;
      slp_d_r   <= sleep_n_pin;
      if (sleep_n_pin)                  slp_cnt_r <= '0;
      else if (~&slp_cnt_r)             slp_cnt_r <= slp_cnt_r + 1'b1;
    end
  end

  // ---------------------------------------------------------------
  // Overcurrent response
  // ---------------------------------------------------------------
  mfm_pkg::mfm_oc_st_t oc_st_r;
  logic [CNT_W_L-1:0]  retry_r;
  wire oc_event = cond.ocp && (ocp_sel != mfm_pkg::MFM_OCP_OFF);

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      oc_st_r <= mfm_pkg::MFM_OC_IDLE;
      retry_r <= '0;
    end else begin
      case (oc_st_r)
        mfm_pkg::MFM_OC_IDLE: begin
          retry_r <= '0;
          if (oc_event) begin
            if (ocp_sel == mfm_pkg::MFM_OCP_RETRY) oc_st_r <= mfm_pkg::MFM_OC_WAIT; // R12
            else                                   oc_st_r <= mfm_pkg::MFM_OC_HOLD;
          end
        end
        mfm_pkg::MFM_OC_HOLD: begin
          // Latched and report modes release on clear once the condition is gone
          if (clear_all && !cond.ocp) oc_st_r <= mfm_pkg::MFM_OC_IDLE; // R12
        end
        mfm_pkg::MFM_OC_WAIT: begin
          retry_r <= retry_r + 1'b1;
          if (retry_r >= CNT_W_L'(RETRY_CYC - 1)) oc_st_r <= mfm_pkg::MFM_OC_IDLE; // R12
        end
        default: oc_st_r <= mfm_pkg::MFM_OC_IDLE;
      endcase
    end
  end

  wire oc_active = (oc_st_r != mfm_pkg::MFM_OC_IDLE);
  wire oc_hiz    = oc_active && (ocp_sel != mfm_pkg::MFM_OCP_REPORT);

  // ---------------------------------------------------------------
  // Latched flags
  // ---------------------------------------------------------------
  logic [W-1:0] st_r;
  logic         trim_r;
  wire          power_lost = cond.supply_uv | cond.analog_rail_undervolt; // R3 R5
  wire          bus_rep    = cond.bus_err && !busrep_dis; // R8
  wire          ovp_act    = cond.ovp && overvolt_enable; // R11
  wire [W-1:0]  set_v;
  assign set_v[mfm_pkg::ST_SUPPLY_OK] = 1'b0;
  assign set_v[mfm_pkg::ST_BUCK_FLT]  = cond.buck_low; // R6
  assign set_v[mfm_pkg::ST_BUCK_DIP]  = cond.buck_low; // R6
  assign set_v[mfm_pkg::ST_PUMP_UV]   = cond.pump_uv; // R10
  assign set_v[mfm_pkg::ST_OVP]       = ovp_act; // R11
  assign set_v[mfm_pkg::ST_OCP]       = oc_event; // R12
  assign set_v[mfm_pkg::ST_BUS_ERR]   = bus_rep; // R8
  assign set_v[mfm_pkg::ST_TRIM_ERR]  = cond.trim_err; // R9
  assign set_v[mfm_pkg::ST_FAULT]     = |set_v[W-1:mfm_pkg::ST_BUCK_FLT];

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      st_r   <= '0;
      trim_r <= 1'b0;
    end else begin
      // Set wins over clear; supply flag reads 0 after loss until cleared
      for (int i = 0; i < W; i++) begin
        if (set_v[i])       st_r[i] <= 1'b1;
        else if (clear_all) st_r[i] <= 1'b0;
      end
      if (power_lost)       st_r[mfm_pkg::ST_SUPPLY_OK] <= 1'b0; // R4
      else if (clear_all)   st_r[mfm_pkg::ST_SUPPLY_OK] <= 1'b1; // R4
      // Trim error ignores the clear command: only sleep pulse or reset
      if (cond.trim_err)    trim_r <= 1'b1; // R9
      else if (slp_clear)   trim_r <= 1'b0; // R9
    end
  end

  // ---------------------------------------------------------------
  // Pin, enables and interrupt
  // ---------------------------------------------------------------
  logic                  fault_n_r;
  mfm_pkg::mfm_enables_t en_r;
  logic [W-1:0]          irq_st_r;
  logic [W-1:0]          mask_r;
  logic                  irq_r;
  logic [15:0]           rdata_r;

  wire bridge_off = power_lost | cond.pump_uv | ovp_act | oc_hiz | trim_r; // R3 R10 R11 R9
  wire fault_now  = cond.buck_low | cond.pump_uv | ovp_act | bus_rep | trim_r // R6 R7 R8
                  | (oc_active | (oc_event & (ocp_sel != mfm_pkg::MFM_OCP_RETRY)));
  wire [W-1:0] live_v = {cond.trim_err, cond.bus_err, cond.ocp, cond.ovp, cond.pump_uv,
                         cond.buck_low, cond.buck_low, fault_now, ~power_lost};
  wire [W-1:0] ev_v   = set_v & ~st_r;
  wire [W-1:0] irq_nxt = ev_v | (irq_st_r & ~(wr_irqst ? reg_wdata[W-1:0] : '0));
  wire [15:0]  rd_nxt =
      (reg_addr == mfm_pkg::ADDR_STATUS) ? 16'(st_r | (W'(trim_r) << mfm_pkg::ST_TRIM_ERR)) :
      (reg_addr == mfm_pkg::ADDR_CTRL)   ? {8'h00, ctrl_r} :
      (reg_addr == mfm_pkg::ADDR_IRQ_ST) ? 16'(irq_st_r) :
      (reg_addr == mfm_pkg::ADDR_IRQ_MK) ? 16'(mask_r) :
      (reg_addr == mfm_pkg::ADDR_LIVE)   ? 16'(live_v) : 16'h0000;

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      fault_n_r <= 1'b1;
      en_r      <= '0;
      irq_st_r  <= '0;
      mask_r    <= mfm_pkg::MASK_RST;
      irq_r     <= 1'b0;
      rdata_r   <= 16'h0000;
    end else begin
      fault_n_r        <= ~fault_now; // R6 R7
      en_r.fets_en     <= ~bridge_off; // R3 R5
      en_r.pump_en     <= ~power_lost; // R3 R5
      en_r.logic_en    <= ~power_lost; // R3 R5
      en_r.buck_en     <= ~cond.buck_low; // R6 R7
      irq_st_r         <= irq_nxt;
      if (wr_mask) mask_r <= reg_wdata[W-1:0];
      irq_r            <= |(irq_nxt & mask_r);
      rdata_r          <= reg_rd ? rd_nxt : 16'h0000;
    end
  end

  assign fault_n_pin = fault_n_r;
  assign enables     = en_r;
  assign irq         = irq_r;
  assign reg_rdata   = rdata_r;

  mfm_full_duty u_full_duty (
    .sys_clk   (sys_clk),
    .rst       (rst),
    .sel_40k   (sel_40k), // R2
    .pwm_in    (pwm_in & en_r.fets_en),
    .ilim_trip (ilim_trip),
    .hs_on     (hs_on)
  );

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  sequence s_clear_pulse;
    clear_all ##0 !power_lost;
  endsequence

  AST_POWER_OFF: assert property (@(posedge sys_clk) disable iff (rst) // R3
    power_lost |=> !en_r.fets_en && !en_r.pump_en && !en_r.logic_en)
    else $error("power loss did not disable stage");
  AST_SUPPLY_HOLD: assert property (@(posedge sys_clk) disable iff (rst) // R4
    (!st_r[mfm_pkg::ST_SUPPLY_OK] && !clear_all) |=> !st_r[mfm_pkg::ST_SUPPLY_OK])
    else $error("supply flag left latched-low state without clear");
  AST_SUPPLY_CLR: assert property (@(posedge sys_clk) disable iff (rst) // R13
    s_clear_pulse |=> st_r[mfm_pkg::ST_SUPPLY_OK])
    else $error("supply flag not restored by clear");
  AST_BUCK_ONLY: assert property (@(posedge sys_clk) disable iff (rst) // R6
    (cond.buck_low && !power_lost && !bridge_off) |=> !en_r.buck_en && en_r.fets_en && !fault_n_r)
    else $error("buck undervoltage response wrong");
  AST_BUCK_LATCH: assert property (@(posedge sys_clk) disable iff (rst) // R7
    ($past(cond.buck_low) && !clear_all) |=> st_r[mfm_pkg::ST_BUCK_DIP] && st_r[mfm_pkg::ST_BUCK_FLT])
    else $error("buck flags not latched");
  AST_BUS_SILENT: assert property (@(posedge sys_clk) disable iff (rst) // R8
    (busrep_dis && cond.bus_err && !cond.buck_low && !cond.pump_uv && !ovp_act && !trim_r
     && !oc_active && !oc_event) |=> fault_n_r && !$rose(st_r[mfm_pkg::ST_BUS_ERR]))
    else $error("disabled bus error drove fault pin");
  AST_TRIM_STICK: assert property (@(posedge sys_clk) disable iff (rst) // R9
    (trim_r && !slp_clear) |=> trim_r && !en_r.fets_en && !fault_n_r)
    else $error("trim error released without sleep pulse");
  AST_PUMP_OFF: assert property (@(posedge sys_clk) disable iff (rst) // R10
    cond.pump_uv |=> !en_r.fets_en && !fault_n_r && st_r[mfm_pkg::ST_PUMP_UV])
    else $error("pump undervoltage response wrong");
  AST_OVP_GATED: assert property (@(posedge sys_clk) disable iff (rst) // R11
    (cond.ovp && !overvolt_enable) |=> !$rose(st_r[mfm_pkg::ST_OVP]))
    else $error("overvoltage latched while disabled");
  AST_OCP_OFF: assert property (@(posedge sys_clk) disable iff (rst) // R12
    (ocp_sel == mfm_pkg::MFM_OCP_OFF && oc_st_r == mfm_pkg::MFM_OC_IDLE) |=> oc_st_r == mfm_pkg::MFM_OC_IDLE)
    else $error("overcurrent acted in disabled mode");
  AST_RETRY_SPAN: assert property (@(posedge sys_clk) disable iff (rst) // R12
    (oc_st_r == mfm_pkg::MFM_OC_WAIT) |-> retry_r < CNT_W_L'(RETRY_CYC))
    else $error("retry window overran");
  // Both clear sources must empty the latched flags in st_r alike; trim_r is not checked here
  AST_CLEAR_ALL: assert property (@(posedge sys_clk) disable iff (rst) // R13
    (clear_all && set_v == '0) |=> st_r[W-1:1] == '0)
    else $error("latched flags survived a clear");
  AST_TRIM_SLEEP: assert property (@(posedge sys_clk) disable iff (rst) // R9
    (slp_clear && !cond.trim_err) |=> !trim_r)
    else $error("trim latch survived a sleep pulse");
endmodule : mfm_top

// *** tb/mfm_mcu_model.sv ***
// Controller model: register port master, sleep pin and PWM input.
// Assumes the register port answers one cycle after a read strobe.
`timescale 1ns/1ps
module mfm_mcu_model (
  input  wire logic        sys_clk,
  output logic [3:0]       reg_addr,
  output logic [15:0]      reg_wdata,
  output logic             reg_wr,
  output logic             reg_rd,
  input  wire logic [15:0] reg_rdata,
  output logic             sleep_n_pin,
  output logic             pwm_in
);
  initial begin
    reg_addr    = 4'h0;
    reg_wdata   = 16'h0000;
    reg_wr      = 1'b0;
    reg_rd      = 1'b0;
    sleep_n_pin = 1'b1;
    pwm_in      = 1'b0;
  end
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge sys_clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge sys_clk);
    reg_wr    <= 1'b0;
  endtask : wr
  // Data stand only in the cycle after the strobe
  task automatic rd(input logic [3:0] a, output logic [15:0] d);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge sys_clk);
    reg_rd   <= 1'b0;
    #1 d = reg_rdata;
  endtask : rd
  // Low for n cycles, then high again: clears latched flags when n is at least the reset width
  task automatic sleep_pulse(input int n);
    @(posedge sys_clk);
    sleep_n_pin <= 1'b0;
    repeat (n) @(posedge sys_clk);
    sleep_n_pin <= 1'b1;
  endtask : sleep_pulse
  task automatic set_pwm(input logic v);
    @(posedge sys_clk);
    pwm_in <= v;
  endtask : set_pwm
endmodule : mfm_mcu_model

// *** tb/testbench.sv ***
// Self-checking bench for the fault manager core.
// Assumes short retry and sleep-pulse counts set by parameter.
`timescale 1ns/1ps
module testbench;
  typedef struct packed {
    logic [7:0] cnd; logic [7:0] ctl; logic fn; logic fr;
    logic [3:0] en; logic [3:0] enm; logic [15:0] st; logic [15:0] stm;
  } mfm_row_t;
  logic sys_clk = 1'b0, rst = 1'b1, ilim_trip = 1'b0, hs_on, fault_n_pin, irq;
  logic reg_wr, reg_rd, sleep_n_pin, pwm_in;
  logic [3:0] reg_addr;
  logic [15:0] reg_wdata, reg_rdata, d;
  mfm_pkg::mfm_cond_t cond = '0;
  mfm_pkg::mfm_enables_t enables;
  int n_errors = 0, n_checks = 0, k;
  mfm_row_t rows[11];
  always #2 sys_clk = ~sys_clk;
  mfm_top #(.RETRY_CYC(20), .RST_PULSE_CYC(4)) i_dut (.sys_clk(sys_clk), .rst(rst), .cond(cond),
    .sleep_n_pin(sleep_n_pin), .pwm_in(pwm_in), .ilim_trip(ilim_trip), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .enables(enables), .hs_on(hs_on), .fault_n_pin(fault_n_pin), .irq(irq));
  mfm_mcu_model i_mcu (.sys_clk(sys_clk), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .sleep_n_pin(sleep_n_pin), .pwm_in(pwm_in));
  task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic end_sim;
    $display("checks %0d mismatches %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : end_sim
  task automatic put(input logic [7:0] c, input int n);
    @(posedge sys_clk);
    cond <= c;
    repeat (n) @(posedge sys_clk);
    #1;
  endtask : put
  task automatic full_duty(input logic sel, input int per);
    i_mcu.wr(4'h1, {14'h0000, sel, 1'b0});
    i_mcu.set_pwm(1'b0);
    i_mcu.set_pwm(1'b1);
    put(8'h00, 5);
    chk("hs_on", {15'h0000, hs_on}, 16'h0001);
    @(posedge sys_clk) ilim_trip <= 1'b1;
    @(posedge sys_clk) ilim_trip <= 1'b0;
    put(8'h00, 2);
    chk("hs_on", {15'h0000, hs_on}, 16'h0000);
    k = 0;
    while (hs_on !== 1'b1 && k < per + 10) begin
      @(posedge sys_clk);
      #1 k++;
    end
    chk("reenable", {15'h0000, (k <= per) && (k >= per - 40)}, 16'h0001);
  endtask : full_duty
  initial begin
    #(4 * 60000) n_errors++;
    end_sim();
  end
  initial begin
    // cond ctl fn fr en enm st stm
    rows[0]  = {8'h80, 8'h00, 2'b11, 4'h0, 4'hE, 16'h0000, 16'h0001};
    rows[1]  = {8'h40, 8'h00, 2'b11, 4'h0, 4'hE, 16'h0000, 16'h0001};
    rows[2]  = {8'h20, 8'h00, 2'b01, 4'hE, 4'hF, 16'h000F, 16'h01FF};
    rows[3]  = {8'h10, 8'h00, 2'b01, 4'h2, 4'hA, 16'h0013, 16'h01FF};
    rows[4]  = {8'h08, 8'h04, 2'b01, 4'h0, 4'h8, 16'h0023, 16'h01FF};
    rows[5]  = {8'h08, 8'h00, 2'b11, 4'h8, 4'h8, 16'h0001, 16'h0023};
    rows[6]  = {8'h04, 8'h00, 2'b00, 4'h0, 4'h8, 16'h0043, 16'h01FF};
    rows[7]  = {8'h04, 8'h20, 2'b00, 4'h8, 4'h8, 16'h0043, 16'h01FF};
    rows[8]  = {8'h04, 8'h30, 2'b11, 4'h8, 4'h8, 16'h0001, 16'h0043};
    rows[9]  = {8'h02, 8'h00, 2'b01, 4'h8, 4'h8, 16'h0083, 16'h01FF};
    rows[10] = {8'h02, 8'h08, 2'b11, 4'h8, 4'h8, 16'h0001, 16'h0083};
    repeat (5) @(posedge sys_clk);
    rst <= 1'b0;
    put(8'h00, 3);
    chk("fault_n", {15'h0000, fault_n_pin}, 16'h0001);
    chk("irq", {15'h0000, irq}, 16'h0000);
    chk("enables", {12'h000, enables}, 16'h000F);
    i_mcu.rd(4'h0, d);
    chk("status", d, 16'h0000);
    i_mcu.wr(4'h1, 16'h0001);
    i_mcu.rd(4'h0, d);
    chk("status", d, 16'h0001);
    $display("test reset done");
    foreach (rows[i]) begin
      i_mcu.wr(4'h1, {8'h00, rows[i].ctl});
      put(rows[i].cnd, 3);
      chk("fault_n", {15'h0000, fault_n_pin}, {15'h0000, rows[i].fn});
      chk("enables", {12'h000, enables & rows[i].enm}, {12'h000, rows[i].en});
      if (rows[i].cnd[7:6] == 2'b00) begin
        i_mcu.rd(4'h0, d);
        chk("status", d & rows[i].stm, rows[i].st);
      end
      put(8'h00, 3);
      chk("fault_n", {15'h0000, fault_n_pin}, {15'h0000, rows[i].fr});
      i_mcu.rd(4'h0, d);
      chk("latched", d & 16'h0001, {15'h0000, rows[i].cnd[7:6] == 2'b00});
      i_mcu.wr(4'h1, {8'h00, rows[i].ctl} | 16'h0001);
      i_mcu.rd(4'h0, d);
      chk("cleared", d, 16'h0001);
      chk("fault_n", {15'h0000, fault_n_pin}, 16'h0001);
      chk("enables", {12'h000, enables}, 16'h000F);
      $display("test row %0d done", i);
    end
    // Trim error survives the clear command, sleep pulse clears all
    put(8'h21, 1);
    put(8'h00, 3);
    chk("fault_n", {15'h0000, fault_n_pin}, 16'h0000);
    chk("fets", {15'h0000, enables.fets_en}, 16'h0000);
    i_mcu.wr(4'h1, 16'h0001);
    i_mcu.rd(4'h0, d);
    chk("status", d & 16'h0100, 16'h0100);
    i_mcu.wr(4'h1, 16'h0000);
    put(8'h20, 3);
    i_mcu.rd(4'h4, d);
    chk("live", d, 16'h000F);
    put(8'h00, 1);
    i_mcu.sleep_pulse(6);
    put(8'h00, 3);
    chk("fault_n", {15'h0000, fault_n_pin}, 16'h0001);
    i_mcu.rd(4'h0, d);
    chk("status", d, 16'h0001);
    $display("test trim and sleep done");
    // Automatic retry: bridge off for the retry span, flag stays
    i_mcu.wr(4'h1, 16'h0010);
    put(8'h04, 2);
    put(8'h00, 8);
    chk("fets", {15'h0000, enables.fets_en}, 16'h0000);
    put(8'h00, 30);
    chk("fets", {15'h0000, enables.fets_en}, 16'h0001);
    chk("fault_n", {15'h0000, fault_n_pin}, 16'h0001);
    i_mcu.rd(4'h0, d);
    chk("status", d, 16'h0043);
    i_mcu.rd(4'h1, d);
    chk("ctrl", d, 16'h0010);
    i_mcu.wr(4'h1, 16'h0001);
    $display("test retry done");
    // Interrupt: raise, mask, unmask, clear; unmapped read
    i_mcu.wr(4'h2, 16'h01FF);
    i_mcu.wr(4'h3, 16'h0010);
    put(8'h10, 3);
    put(8'h00, 3);
    chk("irq", {15'h0000, irq}, 16'h0001);
    i_mcu.rd(4'h2, d);
    chk("irq_st", d & 16'h0010, 16'h0010);
    i_mcu.wr(4'h3, 16'h0000);
    put(8'h00, 2);
    chk("irq", {15'h0000, irq}, 16'h0000);
    i_mcu.wr(4'h3, 16'h0010);
    i_mcu.rd(4'h3, d);
    chk("mask", d, 16'h0010);
    chk("irq", {15'h0000, irq}, 16'h0001);
    i_mcu.wr(4'h2, 16'h01FF);
    put(8'h00, 2);
    chk("irq", {15'h0000, irq}, 16'h0000);
    i_mcu.rd(4'hF, d);
    chk("unmapped", d, 16'h0000);
    i_mcu.wr(4'h1, 16'h0001);
    $display("test irq done");
    full_duty(1'b0, mfm_pkg::PWM20_CYC);
    full_duty(1'b1, mfm_pkg::PWM40_CYC);
    $display("test full duty done");
    end_sim();
  end
endmodule : testbench
